// file: inc/bcr_regs.vh
// register offsets, field positions and masks of the buck configuration bank
// included by the bank and its helpers; definitions only
`ifndef BCR_REGS_VH
`define BCR_REGS_VH

`define BCR_OFS_B2_SLEEP 8'h37
`define BCR_OFS_B2_MODE 8'h38
`define BCR_OFS_B2_CONF 8'h39
`define BCR_OFS_B3_VOLT 8'h3c

// implemented bits per register; the rest read zero
`define BCR_MASK_B2_SLEEP 8'h3f
`define BCR_MASK_B2_MODE 8'h2f
`define BCR_MASK_B2_CONF 8'h7d
`define BCR_MASK_B3_VOLT 8'h1f

// bits loaded from otp; the others reset to zero
`define BCR_OTP_B2_SLEEP 8'h3f
`define BCR_OTP_B2_MODE 8'h0f
`define BCR_OTP_B2_CONF 8'h4d
`define BCR_OTP_B3_VOLT 8'h1f

`define BCR_ZERO_BYTE 8'h00

// field positions
`define BCR_VCODE_HI 4
`define BCR_VCODE_LO 0
`define BCR_RANGE_BIT 5
`define BCR_OFFMODE_BIT 5
`define BCR_SWMODE_HI 3
`define BCR_SWMODE_LO 0
`define BCR_STEP_BIT 6
`define BCR_PHASE_HI 5
`define BCR_PHASE_LO 4
`define BCR_FREQ_HI 3
`define BCR_FREQ_LO 2
`define BCR_ILIM_BIT 0

// register indices inside the bank
`define BCR_NREG 4
`define BCR_IDX_B2_SLEEP 2'h0
`define BCR_IDX_B2_MODE 2'h1
`define BCR_IDX_B2_CONF 2'h2
`define BCR_IDX_B3_VOLT 2'h3

// voltage step timing, in ns, at a 50 ns clock
`define BCR_CLK_PERIOD_NS 50
`define BCR_STEP_FAST_NS 2000
`define BCR_STEP_SLOW_NS 4000

`endif

// file: src/bcr_decode.v
// address decoder of the buck configuration bank
// assumes an 8-bit register offset from the control port
`include "bcr_regs.vh"

module bcr_decode
(
   // offset in
   input wire [7:0] addr,
   // decoded register
   output reg hit,
   output reg [1:0] idx
);

   always @*
   begin
      hit = 1'b1;
      case (addr)
         `BCR_OFS_B2_SLEEP: idx = `BCR_IDX_B2_SLEEP;
         `BCR_OFS_B2_MODE: idx = `BCR_IDX_B2_MODE;
         `BCR_OFS_B2_CONF: idx = `BCR_IDX_B2_CONF;
         `BCR_OFS_B3_VOLT: idx = `BCR_IDX_B3_VOLT;
         default:
         begin
            hit = 1'b0;
            idx = `BCR_IDX_B2_SLEEP;
         end
      endcase
   end

endmodule // bcr_decode

// file: src/bcr_step_timer.v
// voltage stepping tick for the second buck converter
// emits one pulse per 25 mV step interval, fast or slow
`include "bcr_regs.vh"

module bcr_step_timer
(
   // clock and reset
   input wire core_clk,
   input wire rstn,
   // rate select, 1 = slow
   input wire slow,
   // step pulse
   output reg step_tick
);

   // cycle counts fit in the 8-bit counter; cut to width on purpose
   localparam integer fast_full = `BCR_STEP_FAST_NS / `BCR_CLK_PERIOD_NS;
   localparam integer slow_full = `BCR_STEP_SLOW_NS / `BCR_CLK_PERIOD_NS;
   localparam [7:0] fast_cyc = fast_full[7:0];
   localparam [7:0] slow_cyc = slow_full[7:0];

   reg [7:0] cnt_q;
   wire [7:0] limit;

   assign limit = slow ? slow_cyc : fast_cyc;

   always @(posedge core_clk)
   begin
      if (!rstn)
      begin
         cnt_q <= 8'h00;
         step_tick <= 1'b0;
      end
      else if (cnt_q >= limit - 8'h01)
      begin
         cnt_q <= 8'h00;
         step_tick <= 1'b1;
      end
      else
      begin
         cnt_q <= cnt_q + 8'h01;
         step_tick <= 1'b0;
      end
   end

endmodule // bcr_step_timer

// file: src/bcr_bank.v
// second and third buck converter configuration registers
// byte-wide register port from the control-port slave; otp image valid at reset
// Functional notes
// - offset 0x37 bits 4:0 hold buck2 sleep-mode voltage code.
// - offset 0x37 bit 5 picks buck2 range, 0 low, 1 high.
// - offset 0x38 bit 5: after turn-off, 0 fully off, 1 sleep.
// - offset 0x38 bits 3:0 hold buck2 switching mode code.
// - offset 0x39 bits 5:4 select buck2 phase clock.
// - offset 0x39 bits 3:2 select buck2 switching frequency.
// - offset 0x39 bit 0: current limit 2.75 A when 0, 2.0 A when 1.
// - offset 0x3c bits 4:0 hold buck3 normal voltage code.
// - reset loads field values from otp memory, except 0x38 bit 5 and 0x39 bits 5:4, which reset to zero.
// - registers readable and writable at all times, no lock.
`include "bcr_regs.vh"

module bcr_bank
(
   // clock and reset
   input wire core_clk,
   input wire rstn,
   // otp defaults
   input wire [7:0] otp_b2_sleep,
   input wire [7:0] otp_b2_mode,
   input wire [7:0] otp_b2_conf,
   input wire [7:0] otp_b3_volt,
   // register port
   input wire reg_wr,
   input wire reg_rd,
   input wire [7:0] reg_addr,
   input wire [7:0] reg_wdata,
   output reg [7:0] reg_rdata,
   output reg reg_rvalid,
   output wire reg_hit,
   // buck2 controls
   output wire [4:0] buck2_sleep_voltage_code,
   output wire buck2_range_select,
   output wire buck2_off_behaviour,
   output wire [3:0] buck2_switching_mode,
   output wire buck2_step_rate,
   output wire [1:0] buck2_phase_select,
   output wire [1:0] buck2_frequency_select,
   output wire buck2_current_limit,
   output wire buck2_step_tick,
   // buck3 controls
   output wire [4:0] buck3_voltage_code
);

   wire [7:0] regs_q [0:`BCR_NREG-1];
   wire [1:0] idx;

   function [7:0] impl_mask;
      input [1:0] i;
      begin
         case (i)
            `BCR_IDX_B2_SLEEP: impl_mask = `BCR_MASK_B2_SLEEP;
            `BCR_IDX_B2_MODE: impl_mask = `BCR_MASK_B2_MODE;
            `BCR_IDX_B2_CONF: impl_mask = `BCR_MASK_B2_CONF;
            `BCR_IDX_B3_VOLT: impl_mask = `BCR_MASK_B3_VOLT;
            default: impl_mask = `BCR_ZERO_BYTE;
         endcase
      end
   endfunction

   function [7:0] otp_mask;
      input [1:0] i;
      begin
         case (i)
            `BCR_IDX_B2_SLEEP: otp_mask = `BCR_OTP_B2_SLEEP;
            `BCR_IDX_B2_MODE: otp_mask = `BCR_OTP_B2_MODE;
            `BCR_IDX_B2_CONF: otp_mask = `BCR_OTP_B2_CONF;
            `BCR_IDX_B3_VOLT: otp_mask = `BCR_OTP_B3_VOLT;
            default: otp_mask = `BCR_ZERO_BYTE;
         endcase
      end
   endfunction

   wire [7:0] otp_img [0:`BCR_NREG-1];
   assign otp_img[`BCR_IDX_B2_SLEEP] = otp_b2_sleep;
   assign otp_img[`BCR_IDX_B2_MODE] = otp_b2_mode;
   assign otp_img[`BCR_IDX_B2_CONF] = otp_b2_conf;
   assign otp_img[`BCR_IDX_B3_VOLT] = otp_b3_volt;

   bcr_decode u_dec
   (
      .addr(reg_addr),
      .hit(reg_hit),
      .idx(idx)
   );

   // one byte register per index
   genvar g;
   generate
      for (g = 0; g < `BCR_NREG; g = g + 1)
      begin : g_reg
         // each byte has its own flop and a single driver
         localparam integer idx_full = g;
         localparam [1:0] my_idx = idx_full[1:0];
         reg [7:0] byte_q;
         always @(posedge core_clk)
         begin
            if (!rstn)
               byte_q <= otp_img[g] & otp_mask(my_idx);
            else if (reg_wr && reg_hit && idx == my_idx)
               byte_q <= reg_wdata & impl_mask(my_idx);
         end
         assign regs_q[g] = byte_q;
      end
   endgenerate

   // registered read data, one cycle after the strobe
   always @(posedge core_clk)
   begin
      if (!rstn)
      begin
         reg_rdata <= `BCR_ZERO_BYTE;
         reg_rvalid <= 1'b0;
      end
      else
      begin
         reg_rvalid <= reg_rd;
         if (reg_rd)
            reg_rdata <= reg_hit ? (regs_q[idx] & impl_mask(idx)) : `BCR_ZERO_BYTE;
      end
   end

   assign buck2_sleep_voltage_code = regs_q[`BCR_IDX_B2_SLEEP][`BCR_VCODE_HI:`BCR_VCODE_LO];
   assign buck2_range_select = regs_q[`BCR_IDX_B2_SLEEP][`BCR_RANGE_BIT];
   assign buck2_off_behaviour = regs_q[`BCR_IDX_B2_MODE][`BCR_OFFMODE_BIT];
   assign buck2_switching_mode = regs_q[`BCR_IDX_B2_MODE][`BCR_SWMODE_HI:`BCR_SWMODE_LO];
   assign buck2_step_rate = regs_q[`BCR_IDX_B2_CONF][`BCR_STEP_BIT];
   assign buck2_phase_select = regs_q[`BCR_IDX_B2_CONF][`BCR_PHASE_HI:`BCR_PHASE_LO];
   assign buck2_frequency_select = regs_q[`BCR_IDX_B2_CONF][`BCR_FREQ_HI:`BCR_FREQ_LO];
   assign buck2_current_limit = regs_q[`BCR_IDX_B2_CONF][`BCR_ILIM_BIT];
   assign buck3_voltage_code = regs_q[`BCR_IDX_B3_VOLT][`BCR_VCODE_HI:`BCR_VCODE_LO];

   bcr_step_timer u_step
   (
      .core_clk(core_clk),
      .rstn(rstn),
      .slow(buck2_step_rate),
      .step_tick(buck2_step_tick)
   );

endmodule // bcr_bank

// file: verification/bcr_bank_sva.sv
// port assertions of the buck configuration bank
// bound to bcr_bank, sees its ports only
module bcr_bank_sva
(
   // clock and reset
   input wire core_clk,
   input wire rstn,
   // register port
   input wire reg_wr,
   input wire reg_rd,
   input wire [7:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire [7:0] reg_rdata,
   input wire reg_rvalid,
   input wire reg_hit,
   // controls
   input wire [3:0] buck2_switching_mode,
   input wire buck2_current_limit,
   input wire buck2_step_tick,
   input wire [4:0] buck3_voltage_code
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rstn);
   a_rd_answer: assert property (reg_rd |=> reg_rvalid) else $error("read not answered");
   a_rvalid_cause: assert property (reg_rvalid |-> $past(reg_rd)) else $error("stray rvalid");
   a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata)) else $error("rdata moved");
   a_unmapped_zero: assert property (reg_rd && !reg_hit |=> reg_rdata == 8'h00) else $error("unmapped");
   a_hit_decode: assert property (reg_hit == (reg_addr inside {8'h37, 8'h38, 8'h39, 8'h3c}))
      else $error("decode");
   a_mode_write: assert property (reg_wr && reg_addr == 8'h38 |=>
      {4'h0, buck2_switching_mode} == ($past(reg_wdata) & 8'h0f)) else $error("mode");
   a_ilim_write: assert property (reg_wr && reg_addr == 8'h39 |=>
      {7'h0, buck2_current_limit} == ($past(reg_wdata) & 8'h01)) else $error("ilim");
   a_b3_write: assert property (reg_wr && reg_addr == 8'h3c |=>
      {3'h0, buck3_voltage_code} == ($past(reg_wdata) & 8'h1f)) else $error("b3");
   a_tick_pulse: assert property (buck2_step_tick |=> !buck2_step_tick [*8]) else $error("tick");
   c_wr: cover property (reg_wr);
   c_rd: cover property (reg_rvalid);
   c_tick: cover property (buck2_step_tick);
endmodule // bcr_bank_sva
bind bcr_bank bcr_bank_sva chk_u (.core_clk(core_clk), .rstn(rstn), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
   .reg_hit(reg_hit), .buck2_switching_mode(buck2_switching_mode), .buck2_current_limit(buck2_current_limit),
   .buck2_step_tick(buck2_step_tick), .buck3_voltage_code(buck3_voltage_code));

// file: verification/bcr_host_model.sv
// host side of the register port
// drives on falling edges; idle lines show inverted values
module bcr_host_model
(
   // clock
   input wire core_clk,
   // request
   output logic reg_wr = 1'b0,
   output logic reg_rd = 1'b0,
   output logic [7:0] reg_addr = 8'h00,
   output logic [7:0] reg_wdata = 8'h00,
   // answer
   input wire [7:0] reg_rdata,
   input wire reg_rvalid
);
   timeunit 1ns;
   timeprecision 1ns;
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge core_clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge core_clk);
      reg_wr = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~d;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
      @(negedge core_clk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge core_clk);
      reg_rd = 1'b0;
      reg_addr = ~a;
      ok = reg_rvalid;
      d = reg_rdata;
   endtask
endmodule // bcr_host_model

// file: verification/bcr_bank_tb_top.sv
// self-checking bench of the buck configuration bank
// host model drives the register port; each register gets its own otp image
module bcr_bank_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic core_clk = 1'b0;
   logic rstn = 1'b0;
   logic [7:0] oimg [4] = '{8'hff, 8'hff, 8'hff, 8'hff};
   logic [7:0] oxr [4] = '{8'h00, 8'h03, 8'h0c, 8'h10};
   logic wr, rd, hit, rv, ok, rg, off, st, il, tick;
   logic [7:0] ad, wd, rdat, v;
   logic [4:0] sc, b3;
   logic [3:0] md;
   logic [1:0] ph, fr;
   logic [7:0] fld [4];
   logic [7:0] ofs [4] = '{8'h37, 8'h38, 8'h39, 8'h3c};
   logic [7:0] msk [4] = '{8'h3f, 8'h2f, 8'h7d, 8'h1f};
   logic [7:0] omk [4] = '{8'h3f, 8'h0f, 8'h4d, 8'h1f};
   int errors = 0;
   int checks_done = 0;
   always #25 core_clk = ~core_clk;
   assign fld[0] = {2'h0, rg, sc};
   assign fld[1] = {2'h0, off, 1'b0, md};
   assign fld[2] = {1'b0, st, ph, fr, 1'b0, il};
   assign fld[3] = {3'h0, b3};
   bcr_bank dut_u (.core_clk(core_clk), .rstn(rstn), .otp_b2_sleep(oimg[0]), .otp_b2_mode(oimg[1]),
      .otp_b2_conf(oimg[2]), .otp_b3_volt(oimg[3]), .reg_wr(wr), .reg_rd(rd), .reg_addr(ad), .reg_wdata(wd),
      .reg_rdata(rdat), .reg_rvalid(rv), .reg_hit(hit), .buck2_sleep_voltage_code(sc),
      .buck2_range_select(rg), .buck2_off_behaviour(off), .buck2_switching_mode(md), .buck2_step_rate(st),
      .buck2_phase_select(ph), .buck2_frequency_select(fr), .buck2_current_limit(il),
      .buck2_step_tick(tick), .buck3_voltage_code(b3));
   bcr_host_model host_u (.core_clk(core_clk), .reg_wr(wr), .reg_rd(rd), .reg_addr(ad), .reg_wdata(wd),
      .reg_rdata(rdat), .reg_rvalid(rv));
   task automatic print_verdict;
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      checks_done++;
      if (g !== e)
      begin
         errors++;
         $display("MISMATCH %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic rd_chk(input int i, input logic [7:0] e);
      host_u.rd(ofs[i], v, ok);
      chk("rvalid", 8'h01, {7'h0, ok});
      chk("rdata", e, v);
      chk("fields", e, fld[i]);
   endtask
   task automatic t_otp(input logic [7:0] img);
      for (int i = 0; i < 4; i++) oimg[i] = img ^ oxr[i];
      rstn = 1'b0;
      repeat (3) @(negedge core_clk);
      rstn = 1'b1;
      for (int i = 0; i < 4; i++) rd_chk(i, (img ^ oxr[i]) & omk[i]);
   endtask
   task automatic t_rw;
      for (int i = 0; i < 4; i++)
      begin
         host_u.wr(ofs[i], 8'hff);
         rd_chk(i, msk[i]);
         host_u.wr(ofs[i], 8'h00);
         rd_chk(i, 8'h00);
      end
   endtask
   task automatic t_unmapped;
      host_u.wr(8'h3a, 8'hff);
      host_u.rd(8'h3a, v, ok);
      chk("unmapped", 8'h00, v);
      chk("unmapped rvalid", 8'h01, {7'h0, ok});
      rd_chk(0, 8'h00);
      rd_chk(2, 8'h00);
   endtask
   task automatic wait_tick(output int n);
      n = 0;
      do
      begin
         @(negedge core_clk);
         n++;
      end while (tick !== 1'b1 && n < 200);
      if (n >= 200)
      begin
         errors++;
         print_verdict();
      end
   endtask
   task automatic t_step(input logic r, input logic [7:0] e);
      int n;
      host_u.wr(8'h39, {1'b0, r, 6'h00});
      repeat (3) wait_tick(n);
      chk("tick gap", e, n[7:0]);
   endtask
   initial
   begin
      t_otp(8'hff);
      t_rw();
      t_unmapped();
      t_step(1'b0, 8'd40);
      t_step(1'b1, 8'd80);
      t_otp(8'h55);
      print_verdict();
   end
endmodule // bcr_bank_tb_top
